// ### inc/tpw_regs.svh
// register offsets, field positions, reset values and timing counts of the pwm timer
`ifndef TPW_REGS_SVH
`define TPW_REGS_SVH
`define TPW_OFF_CTL_A 8'h00
`define TPW_OFF_CTL_B 8'h04
`define TPW_OFF_COUNT 8'h08
`define TPW_OFF_CMP_A 8'h0C
`define TPW_OFF_CMP_B 8'h10
`define TPW_OFF_FLAGS 8'h14
`define TPW_OFF_PINS 8'h18
`define TPW_WORD_MASK 8'hFC
`define TPW_CTL_A_RST 8'h00
`define TPW_CTL_B_RST 8'h00
`define TPW_CTL_A_WMASK 8'hF3
`define TPW_COM_A_POS 6
`define TPW_COM_B_POS 4
`define TPW_WGM_LO_POS 0
`define TPW_FORCE_A_POS 7
`define TPW_FORCE_B_POS 6
`define TPW_WGM_HI_POS 3
`define TPW_CS_POS 0
`define TPW_OVF_POS 0
`define TPW_OCF_A_POS 1
`define TPW_OCF_B_POS 2
`define TPW_DIR_POS 0
`define TPW_PORT_POS 2
`define TPW_BOTTOM 8'h00
`define TPW_MAX 8'hFF
`define TPW_DIV8_BITS 3
`define TPW_DIV64_BITS 6
`define TPW_DIV256_BITS 8
`define TPW_DIV1024_BITS 10
`define TPW_PC_PERIOD_TICKS 10'h1FE
`define TPW_RESP_OKAY 2'h0
`define TPW_RESP_SLVERR 2'h2
`endif

// ### inc/tpw_pkg.sv
// types of the pwm timer: mode encodings and state records
package tpw_pkg;
   typedef enum logic [2:0] {
      TPW_WGM_NORMAL = 3'h0,
      TPW_WGM_PC_FF = 3'h1,
      TPW_WGM_CTC = 3'h2,
      TPW_WGM_FAST_FF = 3'h3,
      TPW_WGM_PC_OCR = 3'h5,
      TPW_WGM_FAST_OCR = 3'h7
   } tpw_wgm_t;
   typedef enum logic [1:0] {
      TPW_COM_OFF = 2'h0,
      TPW_COM_TOGGLE = 2'h1,
      TPW_COM_CLEAR = 2'h2,
      TPW_COM_SET = 2'h3
   } tpw_com_t;
   typedef enum logic [2:0] {
      TPW_CLS_NONPWM = 3'h1,
      TPW_CLS_FAST = 3'h2,
      TPW_CLS_PC = 3'h4
   } tpw_cls_t;
   typedef struct packed {
      logic [7:0] ctl_a;
      logic wgm_hi;
      logic [2:0] clk_sel;
      logic [7:0] cnt;
      logic up;
      logic [7:0] cmp_a_buf;
      logic [7:0] cmp_b_buf;
      logic [7:0] cmp_a_act;
      logic [7:0] cmp_b_act;
      logic ovf;
      logic ocf_a;
      logic ocf_b;
      logic [1:0] sym_pend;
      logic wave_a;
      logic wave_b;
      logic [1:0] pin_dir;
      logic [1:0] port_val;
      logic pin_a_o;
      logic pin_a_oe;
      logic pin_b_o;
      logic pin_b_oe;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic aw_hold;
      logic w_hold;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tpw_state_t;
   typedef struct packed {
      logic [9:0] div;
   } tpw_pre_state_t;
endpackage : tpw_pkg

// ### core/tpw_prescale.sv
// prescaler producing the timer tick as a clock enable
`timescale 1ns/100ps
`include "tpw_regs.svh"
module tpw_prescale #(
   parameter int DIV_W = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [2:0] clk_sel,
   output logic tick
);
   import tpw_pkg::*;
   tpw_pre_state_t q;
   tpw_pre_state_t d;

   generate
      if (DIV_W < `TPW_DIV1024_BITS || DIV_W > 10) begin : g_bad_width
         $error("tpw_prescale: DIV_W must be 10");
      end
   endgenerate

   // 1, 8, 64, 256, 1024; other selections leave the timer stopped
   always_comb begin
      d = q;
      d.div = q.div + 10'h001;
      case (clk_sel)
         3'h1: tick = 1'b1;
         3'h2: tick = &q.div[`TPW_DIV8_BITS-1:0];
         3'h3: tick = &q.div[`TPW_DIV64_BITS-1:0];
         3'h4: tick = &q.div[`TPW_DIV256_BITS-1:0];
         3'h5: tick = &q.div[`TPW_DIV1024_BITS-1:0];
         default: tick = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end
endmodule : tpw_prescale

// ### core/tpw_wave.sv
// compare output decoder for one channel
`timescale 1ns/100ps
module tpw_wave #(
   parameter bit TOGGLE_OK = 1'b1
) (
   input wire tpw_pkg::tpw_cls_t cls,
   input wire tpw_pkg::tpw_com_t com,
   input wire logic wgm_hi,
   input wire logic match,
   input wire logic force_cmp,
   input wire logic top_step,
   input wire logic bot_step,
   input wire logic up,
   input wire logic cmp_is_top,
   input wire logic sym_fix,
   input wire logic wave_i,
   output logic wave_o
);
   import tpw_pkg::*;
   logic tog_en;
   logic hit;

   assign tog_en = TOGGLE_OK & wgm_hi;
   assign hit = match & ~(cmp_is_top & com[1]);

   always_comb begin
      wave_o = wave_i;
      case (cls)
         TPW_CLS_NONPWM: begin
            if (match || force_cmp) begin
               case (com)
                  TPW_COM_TOGGLE: wave_o = ~wave_i;
                  TPW_COM_CLEAR: wave_o = 1'b0;
                  TPW_COM_SET: wave_o = 1'b1;
                  default: wave_o = wave_i;
               endcase
            end
         end
         TPW_CLS_FAST: begin
            if (com == TPW_COM_TOGGLE) begin
               if (match && tog_en) begin
                  wave_o = ~wave_i;
               end
            end else if (com[1]) begin
               if (hit) begin
                  wave_o = (com == TPW_COM_SET);
               end
               if (top_step) begin
                  wave_o = (com == TPW_COM_CLEAR);
               end
            end
         end
         TPW_CLS_PC: begin
            if (com == TPW_COM_TOGGLE) begin
               if (match && tog_en) begin
                  wave_o = ~wave_i;
               end
            end else if (com[1]) begin
               if (hit) begin
                  wave_o = up ? (com == TPW_COM_SET) : (com == TPW_COM_CLEAR);
               end else if ((top_step && cmp_is_top) || (bot_step && sym_fix)) begin
                  // level a down-count match would leave, so the slope stays symmetric
                  wave_o = (com == TPW_COM_CLEAR);
               end
            end
         end
         default: wave_o = wave_i;
      endcase
   end
endmodule : tpw_wave

// ### core/tpw_timer.sv
// 8-bit phase correct pwm timer with axi4-lite register slave
`timescale 1ns/100ps
`include "tpw_regs.svh"
// Operation
// RULE_01 - waveform_mode 1 or 5 selects dual-slope phase correct pwm
// RULE_02 - top is 0xFF in mode 1, compare_value_a in mode 5
// RULE_03 - counter runs bottom to top, then top back to bottom, repeatedly
// RULE_04 - at top the direction reverses; top lasts exactly one tick
// RULE_05 - overflow_flag sets whenever the phase correct counter reaches bottom
// RULE_06 - out_mode_a 10: clear on up-count match, set on down-count match
// RULE_07 - out_mode_a 11: set on up-count match, clear on down-count match
// RULE_08 - out_mode_a 01 in pwm toggles only with waveform_mode_high; never channel B
// RULE_09 - nonzero out_mode overrides port; pin driven only when its direction is output; the code leaves pin A on the port for out_mode_a 01 in mode 1 or 3
// RULE_10 - compare at bottom gives constant low, at 0xFF constant high, inverted opposite
// RULE_11 - bottom transition without match after leaving MAX or a missed up match
// RULE_12 - with top 0xFF one phase correct period is 510 ticks
// RULE_13 - tick is the clock divided by 1, 8, 64, 256 or 1024
// RULE_14 - non-pwm out_mode 00,01,10,11: disconnect, toggle, clear, set on match
// RULE_15 - fast pwm 10 clears on match, sets at top; 11 the reverse
// RULE_16 - compare equal to top with out_mode high bit ignores match, still acts at top
// RULE_17 - control A: out_mode_a 7:6, out_mode_b 5:4, zero 3:2, mode 1:0, reset 0
// RULE_18 - fully synchronous; the tick enables counting and flag updates
// RULE_19 - channel B phase correct 10 and 11 act like channel A
// RULE_20 - waveform_mode_high lives in control B, joins control A low bits
// RULE_21 - in phase correct pwm compare writes take effect only at top
module tpw_timer #(
   parameter int ADDR_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wave_pin_a_o,
   output logic wave_pin_a_oe,
   output logic wave_pin_b_o,
   output logic wave_pin_b_oe,
   output logic overflow_flag
);
   import tpw_pkg::*;
   tpw_state_t q;
   tpw_state_t d;
   logic [2:0] wgm;
   logic is_pc;
   logic is_fast;
   logic is_nonpwm;
   tpw_cls_t cls;
   logic [7:0] top;
   logic at_top;
   logic at_bot;
   logic eff_up;
   logic tick_raw;
   logic step;
   logic match_a;
   logic match_b;
   logic force_a;
   logic force_b;
   logic wave_a_n;
   logic wave_b_n;
   logic cmp_upd;
   logic set_ovf;
   logic wr_fire;
   logic wr_lane;
   logic [7:0] wr_off;
   logic wr_hit;
   logic [7:0] rd_off;
   logic rd_hit;
   logic [7:0] wbyte;
   logic pin_a_tog_off;

   generate
      if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
         $error("tpw_timer: ADDR_W must lie in 8..32");
      end
   endgenerate

   assign wgm = {q.wgm_hi, q.ctl_a[`TPW_WGM_LO_POS +: 2]}; // RULE_20
   assign is_pc = (wgm == TPW_WGM_PC_FF) || (wgm == TPW_WGM_PC_OCR); // RULE_01
   assign is_fast = (wgm == TPW_WGM_FAST_FF) || (wgm == TPW_WGM_FAST_OCR);
   assign is_nonpwm = ~is_pc & ~is_fast;
   assign cls = is_pc ? TPW_CLS_PC : (is_fast ? TPW_CLS_FAST : TPW_CLS_NONPWM);
   // top taken from the applied compare A, not from the software copy
   assign top = (wgm == TPW_WGM_PC_OCR || wgm == TPW_WGM_FAST_OCR || wgm == TPW_WGM_CTC) ?
                q.cmp_a_act : `TPW_MAX; // RULE_02
   assign at_top = q.cnt == top;
   assign at_bot = q.cnt == `TPW_BOTTOM;
   assign eff_up = at_bot | q.up;
   assign step = clk_en & tick_raw; // RULE_18
   assign match_a = step & (q.cnt == q.cmp_a_act);
   assign match_b = step & (q.cnt == q.cmp_b_act);
   assign cmp_upd = is_nonpwm | (step & at_top); // RULE_21
   assign set_ovf = step & (is_pc ? (~q.up & (q.cnt == 8'h01)) : (is_fast ? at_top : (q.cnt == `TPW_MAX))); // RULE_05

   assign wr_fire = q.aw_hold & q.w_hold & ~q.bvalid;
   assign wr_lane = q.wstrb[0];
   assign wr_off = q.awaddr[7:0] & `TPW_WORD_MASK;
   assign wr_hit = (q.awaddr >> 8) == 32'h0000_0000;
   assign wbyte = q.wdata[7:0];
   assign rd_off = s_axi_araddr[7:0] & `TPW_WORD_MASK;
   assign rd_hit = (s_axi_araddr >> 8) == '0;
   // force strobes act only in non-pwm modes and raise no flag
   assign force_a = wr_fire & wr_hit & wr_lane & (wr_off == `TPW_OFF_CTL_B) & wbyte[`TPW_FORCE_A_POS] & is_nonpwm;
   assign force_b = wr_fire & wr_hit & wr_lane & (wr_off == `TPW_OFF_CTL_B) & wbyte[`TPW_FORCE_B_POS] & is_nonpwm;

   tpw_prescale #(
      .DIV_W(10)
   ) u_prescale (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .clk_sel(q.clk_sel),
      .tick(tick_raw)
   ); // RULE_13

   tpw_wave #(
      .TOGGLE_OK(1'b1)
   ) u_wave_a (
      .cls(cls),
      .com(tpw_com_t'(q.ctl_a[`TPW_COM_A_POS +: 2])),
      .wgm_hi(q.wgm_hi),
      .match(match_a),
      .force_cmp(force_a),
      .top_step(step & at_top),
      .bot_step(step & at_bot),
      .up(eff_up),
      .cmp_is_top(q.cmp_a_act == top),
      .sym_fix(q.sym_pend[0]),
      .wave_i(q.wave_a),
      .wave_o(wave_a_n)
   ); // RULE_06 RULE_07 RULE_08 RULE_10 RULE_11 RULE_14 RULE_15 RULE_16

   // channel B has no toggle option in pwm modes
   tpw_wave #(
      .TOGGLE_OK(1'b0)
   ) u_wave_b (
      .cls(cls),
      .com(tpw_com_t'(q.ctl_a[`TPW_COM_B_POS +: 2])),
      .wgm_hi(q.wgm_hi),
      .match(match_b),
      .force_cmp(force_b),
      .top_step(step & at_top),
      .bot_step(step & at_bot),
      .up(eff_up),
      .cmp_is_top(q.cmp_b_act == top),
      .sym_fix(q.sym_pend[1]),
      .wave_i(q.wave_b),
      .wave_o(wave_b_n)
   ); // RULE_19 RULE_08

   always_comb begin
      d = q;
      // counting, only on ticks
      if (step) begin
         if (is_pc) begin
            if (q.up && q.cnt >= top) begin
               d.up = 1'b0; // RULE_04
               d.cnt = at_bot ? q.cnt : q.cnt - 8'h01;
            end else if (!q.up && at_bot) begin
               d.up = 1'b1; // RULE_03
               d.cnt = q.cnt + 8'h01;
            end else begin
               d.cnt = q.up ? q.cnt + 8'h01 : q.cnt - 8'h01; // RULE_03
            end
         end else if (is_fast || wgm == TPW_WGM_CTC) begin
            d.up = 1'b1;
            d.cnt = at_top ? `TPW_BOTTOM : q.cnt + 8'h01;
         end else begin
            d.up = 1'b1;
            d.cnt = q.cnt + 8'h01;
         end
         if (at_bot) begin
            d.sym_pend = 2'b00;
         end
      end
      d.wave_a = wave_a_n;
      d.wave_b = wave_b_n;
      if (cmp_upd) begin
         d.cmp_a_act = q.cmp_a_buf; // RULE_21
         d.cmp_b_act = q.cmp_b_buf;
         if (is_pc && q.cmp_a_act == `TPW_MAX && q.cmp_a_buf != `TPW_MAX) begin
            d.sym_pend[0] = 1'b1; // RULE_11
         end
         if (is_pc && q.cmp_b_act == `TPW_MAX && q.cmp_b_buf != `TPW_MAX) begin
            d.sym_pend[1] = 1'b1;
         end
      end

      // write channel
      if (q.awready && s_axi_awvalid) begin
         d.aw_hold = 1'b1;
         d.awaddr = 32'(s_axi_awaddr);
      end
      if (q.wready && s_axi_wvalid) begin
         d.w_hold = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (wr_fire) begin
         d.aw_hold = 1'b0;
         d.w_hold = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = `TPW_RESP_OKAY;
         if (!wr_hit || wr_off > `TPW_OFF_PINS) begin
            d.bresp = `TPW_RESP_SLVERR;
         end else if (wr_lane) begin
            case (wr_off)
               `TPW_OFF_CTL_A: d.ctl_a = wbyte & `TPW_CTL_A_WMASK; // RULE_17
               `TPW_OFF_CTL_B: begin
                  d.wgm_hi = wbyte[`TPW_WGM_HI_POS]; // RULE_20
                  d.clk_sel = wbyte[`TPW_CS_POS +: 3];
               end
               `TPW_OFF_COUNT: begin
                  // software count overrides the tick this cycle
                  d.cnt = wbyte;
                  d.sym_pend[0] = d.sym_pend[0] | (is_pc & (wbyte > q.cmp_a_act)); // RULE_11
                  d.sym_pend[1] = d.sym_pend[1] | (is_pc & (wbyte > q.cmp_b_act));
               end
               `TPW_OFF_CMP_A: d.cmp_a_buf = wbyte;
               `TPW_OFF_CMP_B: d.cmp_b_buf = wbyte;
               `TPW_OFF_FLAGS: begin
                  d.ovf = q.ovf & ~wbyte[`TPW_OVF_POS];
                  d.ocf_a = q.ocf_a & ~wbyte[`TPW_OCF_A_POS];
                  d.ocf_b = q.ocf_b & ~wbyte[`TPW_OCF_B_POS];
               end
               `TPW_OFF_PINS: begin
                  d.pin_dir = wbyte[`TPW_DIR_POS +: 2];
                  d.port_val = wbyte[`TPW_PORT_POS +: 2];
               end
               default: d.bresp = `TPW_RESP_SLVERR;
            endcase
         end
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // set after the clear, so an event in the clearing cycle survives
      d.ovf = d.ovf | set_ovf; // RULE_05
      d.ocf_a = d.ocf_a | match_a;
      d.ocf_b = d.ocf_b | match_b;
      d.awready = ~d.aw_hold & ~d.bvalid;
      d.wready = ~d.w_hold & ~d.bvalid;

      // read channel
      if (q.arready && s_axi_arvalid) begin
         d.rvalid = 1'b1;
         d.rresp = `TPW_RESP_OKAY;
         d.rdata = 32'h0000_0000;
         case (rd_off)
            `TPW_OFF_CTL_A: d.rdata[7:0] = q.ctl_a; // RULE_17
            `TPW_OFF_CTL_B: d.rdata[7:0] = {4'h0, q.wgm_hi, q.clk_sel};
            `TPW_OFF_COUNT: d.rdata[7:0] = q.cnt;
            `TPW_OFF_CMP_A: d.rdata[7:0] = q.cmp_a_buf;
            `TPW_OFF_CMP_B: d.rdata[7:0] = q.cmp_b_buf;
            `TPW_OFF_FLAGS: d.rdata[2:0] = {q.ocf_b, q.ocf_a, q.ovf};
            `TPW_OFF_PINS: d.rdata[3:0] = {q.port_val, q.pin_dir};
            default: d.rresp = `TPW_RESP_SLVERR;
         endcase
         if (!rd_hit) begin
            d.rresp = `TPW_RESP_SLVERR;
         end
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      d.arready = ~d.rvalid;

      // pin override and driver enable
      pin_a_tog_off = (d.ctl_a[`TPW_COM_A_POS +: 2] == TPW_COM_TOGGLE) & d.ctl_a[`TPW_WGM_LO_POS] & ~d.wgm_hi; // RULE_08
      d.pin_a_o = (d.ctl_a[`TPW_COM_A_POS +: 2] != TPW_COM_OFF && !pin_a_tog_off) ? d.wave_a : d.port_val[0]; // RULE_09
      d.pin_b_o = (d.ctl_a[`TPW_COM_B_POS +: 2] != TPW_COM_OFF) ? d.wave_b : d.port_val[1];
      d.pin_a_oe = d.pin_dir[0]; // RULE_09
      d.pin_b_oe = d.pin_dir[1];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign wave_pin_a_o = q.pin_a_o;
   assign wave_pin_a_oe = q.pin_a_oe;
   assign wave_pin_b_o = q.pin_b_o;
   assign wave_pin_b_oe = q.pin_b_oe;
   assign overflow_flag = q.ovf;

   // ticks between bottoms, for the period check only
   logic [9:0] per_cnt;
   logic per_ok;
   always_ff @(posedge aclk) begin
      if (!aresetn || !(wgm == TPW_WGM_PC_FF) || wr_fire) begin
         per_cnt <= 10'h000;
         per_ok <= 1'b0;
      end else if (step) begin
         per_cnt <= set_ovf ? 10'h000 : per_cnt + 10'h001;
         per_ok <= per_ok | set_ovf;
      end
   end

   a_top_reverse: assert property (@(posedge aclk) disable iff (!aresetn)
      step && is_pc && q.up && at_top && !at_bot && !wr_fire |=> !q.up && q.cnt == $past(q.cnt) - 8'h01)
      else $error("counter did not turn at top"); // RULE_04
   a_pc_top_ff: assert property (@(posedge aclk) disable iff (!aresetn)
      step && wgm == TPW_WGM_PC_FF && q.up && q.cnt == 8'hFE && !wr_fire |=> q.cnt == 8'hFF)
      else $error("mode 1 top is not 0xFF"); // RULE_02
   a_ovf_bottom: assert property (@(posedge aclk) disable iff (!aresetn)
      step && is_pc && !q.up && q.cnt == 8'h01 |=> q.ovf && q.cnt == 8'h00)
      else $error("overflow not set at bottom"); // RULE_05
   a_clear_up: assert property (@(posedge aclk) disable iff (!aresetn)
      match_a && is_pc && eff_up && q.ctl_a[7:6] == 2'h2 && q.cmp_a_act != top |=> !q.wave_a)
      else $error("up-count match did not clear"); // RULE_06
   a_set_up: assert property (@(posedge aclk) disable iff (!aresetn)
      match_a && is_pc && eff_up && q.ctl_a[7:6] == 2'h3 && q.cmp_a_act != top |=> q.wave_a)
      else $error("inverted up-count match did not set"); // RULE_07
   a_toggle_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      match_a && !is_nonpwm && q.ctl_a[7:6] == 2'h1 |=> q.wave_a == ($past(q.wave_a) ^ $past(q.wgm_hi)))
      else $error("pwm toggle not gated by mode high bit"); // RULE_08
   a_pin_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ctl_a[7:6] != 2'h0 && !(q.ctl_a[7:6] == 2'h1 && q.ctl_a[0] && !q.wgm_hi) |-> wave_pin_a_o == q.wave_a)
      else $error("pin does not follow waveform"); // RULE_09
   a_nonpwm_tog: assert property (@(posedge aclk) disable iff (!aresetn)
      match_a && is_nonpwm && q.ctl_a[7:6] == 2'h1 |=> q.wave_a != $past(q.wave_a))
      else $error("non-pwm toggle missed"); // RULE_14
   a_pc_period: assert property (@(posedge aclk) disable iff (!aresetn)
      set_ovf && per_ok && wgm == TPW_WGM_PC_FF |-> per_cnt == `TPW_PC_PERIOD_TICKS - 10'h001)
      else $error("phase correct period is not 510 ticks"); // RULE_12
   a_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
      !clk_en |=> q.cnt == $past(q.cnt) && q.up == $past(q.up))
      else $error("state moved while enable low"); // RULE_18
   a_cmp_at_top: assert property (@(posedge aclk) disable iff (!aresetn)
      is_pc && $past(is_pc) && q.cmp_b_act != $past(q.cmp_b_act) |-> $past(step && at_top))
      else $error("compare applied away from top"); // RULE_21
endmodule : tpw_timer

// ### sim/tb.sv
// self-checking testbench of the pwm timer through its axi4-lite registers and pins
`timescale 1ns/100ps
`include "tpw_regs.svh"
module tb;
   logic aclk, aresetn, clk_en;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rd_v;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, resp;
   logic pa_o, pa_oe, pb_o, pb_oe, ovf;
   int n_mismatch, total_checks, cyc, p, na, nb;
   tpw_timer dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wave_pin_a_o(pa_o), .wave_pin_a_oe(pa_oe), .wave_pin_b_o(pb_o), .wave_pin_b_oe(pb_oe),
      .overflow_flag(ovf));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) cyc <= cyc + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask : chk
   // wr and rd each start one edge late so no signal is driven twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bit done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bit done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rd_v = rdata;
            resp = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
   endtask : rd
   // cycles between two overflow settings, clk_en withdrawn for stall cycles in between
   task automatic ovf_period(input int stall);
      int t, n;
      wr(`TPW_OFF_FLAGS, 8'h07);
      n = 0;
      while (!ovf && n < 20000) begin
         @(posedge aclk);
         n++;
      end
      t = cyc;
      wr(`TPW_OFF_FLAGS, 8'h01);
      if (stall > 0) begin
         clk_en <= 1'b0;
         repeat (stall) @(posedge aclk);
         clk_en <= 1'b1;
      end
      while (!ovf && n < 40000) begin
         @(posedge aclk);
         n++;
      end
      p = cyc - t;
   endtask : ovf_period
   // duty measured as high count over whole periods, so phase does not matter
   task automatic count_hi(input int len);
      na = 0;
      nb = 0;
      repeat (len) begin
         @(posedge aclk);
         na += pa_o;
         nb += pb_o;
      end
   endtask : count_hi
   task automatic t_regs;
      rd(`TPW_OFF_CTL_A);
      chk(rd_v, 32'h0, "ctl_a reset");
      wr(`TPW_OFF_CTL_A, 8'hFF);
      rd(`TPW_OFF_CTL_A);
      chk(rd_v, 32'hF3, "ctl_a zero bits");
      wr(8'h1C, 8'h55);
      chk(resp, `TPW_RESP_SLVERR, "unmapped write");
      rd(8'h1C);
      chk(resp, `TPW_RESP_SLVERR, "unmapped read");
      $display("test regs done");
   endtask : t_regs
   task automatic t_period;
      wr(`TPW_OFF_CTL_A, 8'h01);
      for (int i = 0; i < 2; i++) begin
         wr(`TPW_OFF_CTL_B, (i == 0) ? 8'h01 : 8'h02);
         ovf_period(0);
         chk(p, 510 << (3 * i), "pc period");
      end
      wr(`TPW_OFF_CTL_B, 8'h01);
      ovf_period(100);
      chk(p, 610, "stalled period");
      $display("test period done");
   endtask : t_period
   task automatic t_pwm;
      logic [7:0] cv [3] = '{8'h80, 8'h00, 8'hFF};
      int ex [2][3] = '{'{256, 0, 510}, '{254, 510, 0}};
      wr(`TPW_OFF_PINS, 8'h03);
      for (int m = 0; m < 2; m++) begin
         for (int k = 0; k < 3; k++) begin
            wr(`TPW_OFF_CMP_A, cv[k]);
            wr(`TPW_OFF_CMP_B, cv[k]);
            wr(`TPW_OFF_CTL_A, (m == 0) ? 8'hA1 : 8'hF1);
            repeat (1100) @(posedge aclk);
            count_hi(510);
            chk(na, ex[m][k], "duty a");
            chk(nb, ex[m][k], "duty b");
         end
      end
      $display("test pwm done");
   endtask : t_pwm
   task automatic t_mode5;
      wr(`TPW_OFF_CMP_A, 8'h40);
      wr(`TPW_OFF_CTL_A, 8'h41);
      wr(`TPW_OFF_CTL_B, 8'h09);
      // let the new top be applied before the period is timed
      repeat (600) @(posedge aclk);
      ovf_period(0);
      chk(p, 128, "top from compare");
      count_hi(256);
      chk(na, 128, "toggle at match");
      wr(`TPW_OFF_CTL_B, 8'h01);
      wr(`TPW_OFF_PINS, 8'h07);
      repeat (600) @(posedge aclk);
      count_hi(510);
      chk(na, 510, "toggle disconnected");
      $display("test mode5 done");
   endtask : t_mode5
   task automatic t_nonpwm;
      int ex [3] = '{256, 0, 512};
      wr(`TPW_OFF_PINS, 8'h03);
      wr(`TPW_OFF_CMP_A, 8'h80);
      for (int c = 1; c < 4; c++) begin
         wr(`TPW_OFF_CTL_A, 8'(c << 6));
         repeat (600) @(posedge aclk);
         count_hi(512);
         chk(na, ex[c - 1], "non-pwm action");
      end
      // timer stopped so only the strobe can move the output
      wr(`TPW_OFF_CTL_B, 8'h00);
      wr(`TPW_OFF_CTL_A, 8'h80);
      chk(pa_o, 1'b1, "no force yet");
      wr(`TPW_OFF_CTL_B, 8'h80);
      chk(pa_o, 1'b0, "forced clear");
      wr(`TPW_OFF_CTL_A, 8'h00);
      wr(`TPW_OFF_PINS, 8'h08);
      repeat (3) @(posedge aclk);
      chk({pa_oe, pb_oe, pb_o}, 3'b001, "pins as port");
      $display("test nonpwm done");
   endtask : t_nonpwm
   task automatic t_fast;
      logic [7:0] cv [2] = '{8'h80, 8'hFF};
      int ex [2] = '{129, 256};
      wr(`TPW_OFF_CTL_B, 8'h01);
      for (int k = 0; k < 2; k++) begin
         wr(`TPW_OFF_CMP_A, cv[k]);
         wr(`TPW_OFF_CTL_A, 8'h83);
         repeat (600) @(posedge aclk);
         count_hi(256);
         chk(na, ex[k], "fast pwm duty");
      end
      $display("test fast done");
   endtask : t_fast
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
      {clk_en, wstrb, cyc, n_mismatch, total_checks} = {1'b1, 4'hF, 96'h0};
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_period();
      t_pwm();
      t_mode5();
      t_nonpwm();
      t_fast();
      stop_test();
   end
   // about three times the expected run length
   initial begin
      #800000;
      n_mismatch++;
      $display("watchdog expired");
      stop_test();
   end
endmodule : tb
